// *** shared/adc_serial_pkg.sv ***
// constants, control byte layout and state codes of the serial converter interface
`default_nettype none
package adc_serial_pkg;
    // ****************************************************************
    // clock and timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 50;
    localparam int CONV_TIME_NS = 25000;
    localparam int RESULT_BITS = 8;
    localparam int STEP_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS / RESULT_BITS;
    localparam logic [15:0] STEP_CYCLES_RST = 16'(STEP_CYCLES);
    localparam logic [3:0] EXT_MSB_FALL = 4'h2;
    localparam logic [3:0] EXT_LAST_FALL = 4'h9;
    localparam logic [3:0] INT_MSB_FALL = 4'h2;
    localparam logic [2:0] CTRL_LAST_BIT = 3'h7;

    // ****************************************************************
    // control byte fields
    // ****************************************************************
    localparam int CB_CHAN_HI = 6;
    localparam int CB_CHAN_LO = 4;
    localparam int CB_POLARITY = 3;
    localparam int CB_INPUT_CFG = 2;
    localparam int CB_POWER_KEEP = 1;
    localparam int CB_CLOCK_MODE = 0;
    localparam logic CLOCK_MODE_EXT = 1'b1;
    localparam logic CLOCK_MODE_RST = 1'b0;
    localparam logic [7:0] CTRL_BYTE_RST = 8'h00;

    // ****************************************************************
    // register port
    // ****************************************************************
    localparam int REG_AW = 4;
    localparam logic [3:0] REG_STEP = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_RESULT = 4'h8;
    localparam logic [3:0] REG_CTRL_BYTE = 4'hC;

    // ****************************************************************
    // pin synchroniser reset levels: {shutdown_n, din, sclk, cs_n}
    // ****************************************************************
    localparam logic [3:0] PIN_SYNC_RST = 4'h9;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_EXT_CONV = 4'b0010,
        ST_INT_CONV = 4'b0100,
        ST_HALT = 4'b1000
    } conv_state_t;
endpackage
`default_nettype wire

// *** hdl/pin_sync.sv ***
// two-stage synchroniser for a group of asynchronous pins
`default_nettype none
module pin_sync
    import adc_serial_pkg::*;
#(
    parameter int W = 4,
    parameter logic [W-1:0] RST_VAL = '0
)
(
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    logic [W-1:0] meta_r;

    // first stage feeds only the second
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            meta_r <= RST_VAL;
            o_sync <= RST_VAL;
        end
        else
        begin
            meta_r <= i_async;
            o_sync <= meta_r;
        end
    end
endmodule
`default_nettype wire

// *** hdl/sar_core.sv ***
// successive-approximation register: one bit decision per step
`default_nettype none
module sar_core
    import adc_serial_pkg::*;
#(
    parameter int W = RESULT_BITS
)
(
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_start,
    input wire logic i_step,
    input wire logic [W-1:0] i_code,
    output logic o_bit,
    output logic o_done,
    output logic [W-1:0] o_result
);
    logic [W-1:0] hold_r;
    logic [W-1:0] mask_r;
    logic [W-1:0] trial;

    // comparator: keep the trial bit when the held input reaches it
    assign trial = o_result | mask_r;
    assign o_bit = (hold_r >= trial);
    assign o_done = (mask_r == '0);

    // track/hold captured at start, so the input may move during conversion
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            hold_r <= '0;
            mask_r <= '0;
            o_result <= '0;
        end
        else if (i_start)
        begin
            hold_r <= i_code;
            mask_r <= {1'b1, {(W-1){1'b0}}};
            o_result <= '0;
        end
        else if (i_step && !o_done)
        begin
            if (o_bit)
                o_result <= trial;
            mask_r <= mask_r >> 1;
        end
    end
endmodule
`default_nettype wire

// *** hdl/adc_serial_if.sv ***
// serial control and readout of an 8-bit successive-approximation converter
`default_nettype none
module adc_serial_if
    import adc_serial_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_chip_sel_n,
    input wire logic i_serial_clk,
    input wire logic i_serial_in,
    input wire logic i_shutdown_n,
    input wire logic [RESULT_BITS-1:0] i_analog_code,
    input wire logic [REG_AW-1:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [31:0] o_reg_rdata,
    output logic o_serial_out,
    output logic o_serial_out_oe,
    output logic o_conv_strobe,
    output logic o_conv_strobe_oe,
    output logic [2:0] o_channel_pick,
    output logic o_polarity_sel,
    output logic o_input_config_sel,
    output logic o_powered
);
    // ****************************************************************
    // pin synchronisers and edge detection
    // ****************************************************************
    logic [3:0] pins_s;
    logic cs_s, sclk_s, din_s, shutdown_n_s;
    logic sclk_d_r, cs_d_r;
    logic sclk_rise, sclk_fall, cs_rise, cs_fall;

    pin_sync #(.W(4), .RST_VAL(PIN_SYNC_RST)) u_pin_sync (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_async({i_shutdown_n, i_serial_in, i_serial_clk, i_chip_sel_n}),
        .o_sync(pins_s)
    );

    assign {shutdown_n_s, din_s, sclk_s, cs_s} = pins_s;

    // previous values of the second stage only
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            sclk_d_r <= 1'b0;
            cs_d_r <= 1'b1;
        end
        else
        begin
            sclk_d_r <= sclk_s;
            cs_d_r <= cs_s;
        end
    end

    assign sclk_rise = sclk_s && !sclk_d_r;
    assign sclk_fall = !sclk_s && sclk_d_r;
    assign cs_rise = cs_s && !cs_d_r;
    assign cs_fall = !cs_s && cs_d_r;

    // ****************************************************************
    // state, control byte and start qualification
    // ****************************************************************
    conv_state_t state_r;
    logic [7:0] ctrl_r;
    logic clk_mode_r;
    logic rx_active_r, byte_pend_r;
    logic [2:0] rx_cnt_r;
    logic [7:0] rx_sh_r;
    logic msb_shown_r, toggled_r, start_ok, launch, launch_ext;
    logic [3:0] ext_k_r;
    logic [15:0] step_cfg_r, step_cnt_r;
    logic int_step, ext_step, sar_step, sar_bit, sar_done;
    logic [RESULT_BITS-1:0] sar_result, fmt_result;
    logic int_ready_r;
    logic [1:0] post_cnt_r;
    logic [RESULT_BITS-1:0] out_sh_r, result_r;
    logic strobe_r, dout_r;
    logic conv_end;

    // start bit allowed when idle, once the msb is out, or after a cs toggle
    assign start_ok = shutdown_n_s && (state_r == ST_IDLE || msb_shown_r || toggled_r);
    // conversion begins on the fall that follows the eighth control bit
    assign launch = byte_pend_r && sclk_fall && !cs_s && shutdown_n_s;
    assign launch_ext = rx_sh_r[CB_CLOCK_MODE] == CLOCK_MODE_EXT;

    // input shifter: leading zeros ignored, cs high clears the detector
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rx_active_r <= 1'b0;
            rx_cnt_r <= 3'h0;
            rx_sh_r <= CTRL_BYTE_RST;
            byte_pend_r <= 1'b0;
        end
        else if (cs_s)
        begin
            rx_active_r <= 1'b0;
            rx_cnt_r <= 3'h0;
            byte_pend_r <= 1'b0;
        end
        else if (sclk_rise)
        begin
            if (!rx_active_r)
            begin
                if (din_s && start_ok)
                begin
                    rx_active_r <= 1'b1;
                    rx_sh_r <= 8'h01;
                    rx_cnt_r <= 3'h1;
                end
            end
            else
            begin
                rx_sh_r <= {rx_sh_r[6:0], din_s};
                rx_cnt_r <= rx_cnt_r + 3'h1;
                if (rx_cnt_r == CTRL_LAST_BIT)
                begin
                    rx_active_r <= 1'b0;
                    byte_pend_r <= 1'b1;
                end
            end
        end
        else if (launch)
            byte_pend_r <= 1'b0;
    end

    // abort marker: a cs toggle during a conversion frees the start detector
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
            toggled_r <= 1'b0;
        else if (cs_rise && state_r != ST_IDLE)
            toggled_r <= 1'b1;
        else if (launch)
            toggled_r <= 1'b0;
    end

    // control byte fields latched at launch
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            ctrl_r <= CTRL_BYTE_RST;
            clk_mode_r <= CLOCK_MODE_RST;
        end
        else if (launch)
        begin
            ctrl_r <= rx_sh_r;
            clk_mode_r <= launch_ext;
        end
    end

    assign o_channel_pick = ctrl_r[CB_CHAN_HI:CB_CHAN_LO];
    assign o_polarity_sel = ctrl_r[CB_POLARITY];
    assign o_input_config_sel = ctrl_r[CB_INPUT_CFG];

    // ****************************************************************
    // conversion sequencing
    // ****************************************************************
    assign ext_step = state_r == ST_EXT_CONV && sclk_fall && !cs_s && !launch
        && ext_k_r >= (EXT_MSB_FALL - 4'h1);
    assign int_step = state_r == ST_INT_CONV && step_cnt_r == 16'h0001 && !sar_done;
    assign sar_step = ext_step || int_step;
    assign conv_end = (state_r == ST_EXT_CONV && ext_step && ext_k_r == EXT_LAST_FALL - 4'h1)
        || (state_r == ST_INT_CONV && sar_done);
    // bipolar results leave as two's complement
    assign fmt_result = sar_result ^ {ctrl_r[CB_POLARITY] ? 1'b0 : 1'b1, {(RESULT_BITS-1){1'b0}}};

    // main state: a new launch always wins, which is also the abort path
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_r <= ST_IDLE;
            ext_k_r <= 4'h0;
        end
        else if (!shutdown_n_s)
            state_r <= ST_HALT;
        else if (launch)
        begin
            state_r <= launch_ext ? ST_EXT_CONV : ST_INT_CONV;
            ext_k_r <= 4'h0;
        end
        else
        begin
            case (state_r)
                ST_IDLE: state_r <= ST_IDLE;
                ST_EXT_CONV:
                begin
                    if (sclk_fall && !cs_s)
                        ext_k_r <= ext_k_r + 4'h1;
                    if (conv_end)
                        state_r <= ST_IDLE;
                end
                ST_INT_CONV:
                begin
                    if (conv_end)
                        state_r <= ST_IDLE;
                end
                ST_HALT: state_r <= ST_IDLE;
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // internal conversion clock: one step enable per divider wrap
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
            step_cnt_r <= STEP_CYCLES_RST;
        else if (launch || step_cnt_r == 16'h0001 || step_cnt_r == 16'h0000)
            step_cnt_r <= step_cfg_r;
        else
            step_cnt_r <= step_cnt_r - 16'h0001;
    end

    sar_core #(.W(RESULT_BITS)) u_sar (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_start(launch),
        .i_step(sar_step),
        .i_code(i_analog_code),
        .o_bit(sar_bit),
        .o_done(sar_done),
        .o_result(sar_result)
    );

    // power follows start bits; without power_keep_bit it drops after one result
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_powered <= 1'b0;
        else if (!shutdown_n_s)
            o_powered <= 1'b0;
        else if (sclk_rise && !cs_s && !rx_active_r && din_s && start_ok)
            o_powered <= 1'b1;
        else if (conv_end && !ctrl_r[CB_POWER_KEEP])
            o_powered <= 1'b0;
    end

    // ****************************************************************
    // strobe and serial output
    // ****************************************************************
    // strobe: high two periods in external mode, low while converting internally
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
            strobe_r <= 1'b1;
        else if (launch)
            strobe_r <= launch_ext;
        else if (state_r == ST_INT_CONV && sar_done)
            strobe_r <= 1'b1;
        else if (state_r == ST_EXT_CONV && sclk_fall && !cs_s && ext_k_r == EXT_MSB_FALL - 4'h1)
            strobe_r <= 1'b0;
        else if (cs_fall && clk_mode_r == CLOCK_MODE_EXT)
            strobe_r <= 1'b0;
    end

    // finished internal result waits in its own register until read
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            int_ready_r <= 1'b0;
            post_cnt_r <= 2'h0;
            out_sh_r <= '0;
        end
        else if (launch)
            int_ready_r <= 1'b0;
        else if (state_r == ST_INT_CONV && sar_done)
        begin
            int_ready_r <= 1'b1;
            post_cnt_r <= 2'h0;
            out_sh_r <= fmt_result;
        end
        else if (int_ready_r && sclk_fall && !cs_s)
        begin
            if (post_cnt_r != INT_MSB_FALL[1:0])
                post_cnt_r <= post_cnt_r + 2'h1;
            if (post_cnt_r + 2'h1 >= INT_MSB_FALL[1:0])
                out_sh_r <= {out_sh_r[RESULT_BITS-2:0], 1'b0};
        end
    end

    // output data changes only on falling edges; zeros once the bits run out
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            dout_r <= 1'b0;
            msb_shown_r <= 1'b0;
        end
        else if (sclk_fall && !cs_s)
        begin
            if (launch)
            begin
                dout_r <= 1'b0;
                msb_shown_r <= 1'b0;
            end
            else if (ext_step)
            begin
                dout_r <= (ext_k_r == EXT_MSB_FALL - 4'h1) ? sar_bit ^ !ctrl_r[CB_POLARITY] : sar_bit;
                if (ext_k_r == EXT_MSB_FALL - 4'h1)
                    msb_shown_r <= 1'b1;
            end
            else if (int_ready_r && post_cnt_r + 2'h1 >= INT_MSB_FALL[1:0])
            begin
                dout_r <= out_sh_r[RESULT_BITS-1];
                msb_shown_r <= 1'b1;
            end
            else
                dout_r <= 1'b0;
        end
    end

    assign o_serial_out = dout_r;
    assign o_conv_strobe = strobe_r;
    assign o_serial_out_oe = !cs_s;
    // internal mode keeps the strobe driven so an idle host can still poll it
    assign o_conv_strobe_oe = (clk_mode_r == CLOCK_MODE_EXT) ? !cs_s : 1'b1;

    // ****************************************************************
    // register port
    // ****************************************************************
    // result copy for software, updated once per conversion
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
            result_r <= '0;
        else if (conv_end)
            result_r <= (state_r == ST_EXT_CONV) ? fmt_result ^ {7'h00, sar_bit} : fmt_result;
    end

    // step divider is writable; zero would stall the divider, so it is raised to one
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
            step_cfg_r <= STEP_CYCLES_RST;
        else if (i_reg_wr && i_reg_addr == REG_STEP)
            step_cfg_r <= (i_reg_wdata[15:0] == 16'h0000) ? 16'h0001 : i_reg_wdata[15:0];
    end

    // read data appear the cycle after the strobe; unmapped reads give zero
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_reg_rdata <= 32'h0000_0000;
        else if (i_reg_rd)
        begin
            case (i_reg_addr)
                REG_STEP: o_reg_rdata <= {16'h0000, step_cfg_r};
                REG_STATUS: o_reg_rdata <= {24'h00_0000, state_r, o_powered, clk_mode_r, int_ready_r, strobe_r};
                REG_RESULT: o_reg_rdata <= {24'h00_0000, result_r};
                REG_CTRL_BYTE: o_reg_rdata <= {24'h00_0000, ctrl_r};
                default: o_reg_rdata <= 32'h0000_0000;
            endcase
        end
        else
            o_reg_rdata <= 32'h0000_0000;
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    sequence s_ext_launch;
        launch && launch_ext;
    endsequence
    sequence s_int_busy;
        !strobe_r [*8];
    endsequence

    property p_ext_strobe_up;
        s_ext_launch |=> strobe_r && state_r == ST_EXT_CONV && ext_k_r == 4'h0;
    endproperty
    a_ext_strobe_up: assert property (p_ext_strobe_up) else $error("strobe not raised at launch");

    property p_ext_strobe_drop;
        (state_r == ST_EXT_CONV && ext_k_r == 4'h1 && sclk_fall && !cs_s && !launch) |=> !strobe_r && msb_shown_r;
    endproperty
    a_ext_strobe_drop: assert property (p_ext_strobe_drop) else $error("strobe not dropped with msb");

    property p_zero_tail;
        (state_r == ST_IDLE && clk_mode_r == CLOCK_MODE_EXT && sclk_fall && !cs_s && !launch) |=> !dout_r;
    endproperty
    a_zero_tail: assert property (p_zero_tail) else $error("nonzero bit after result");

    property p_ext_release;
        (cs_s && clk_mode_r == CLOCK_MODE_EXT) |-> !o_conv_strobe_oe && !o_serial_out_oe;
    endproperty
    a_ext_release: assert property (p_ext_release) else $error("outputs driven with cs high");

    property p_int_strobe_driven;
        clk_mode_r != CLOCK_MODE_EXT |-> o_conv_strobe_oe && (o_serial_out_oe == !cs_s);
    endproperty
    a_int_strobe_driven: assert property (p_int_strobe_driven) else $error("strobe released in internal mode");

    property p_int_strobe_low;
        (launch && !launch_ext && step_cfg_r > 16'h0001) |=> s_int_busy;
    endproperty
    a_int_strobe_low: assert property (p_int_strobe_low) else $error("strobe rose early");

    property p_launch_cause;
        launch |-> $past(byte_pend_r) && !sclk_s && rx_cnt_r == 3'h0;
    endproperty
    a_launch_cause: assert property (p_launch_cause) else $error("conversion began without full byte");

    property p_cs_clears_rx;
        cs_s |=> !rx_active_r && rx_cnt_r == 3'h0 && !byte_pend_r;
    endproperty
    a_cs_clears_rx: assert property (p_cs_clears_rx) else $error("shifter active with cs high");

    property p_int_msb;
        (int_ready_r && sclk_fall && !cs_s && !launch && post_cnt_r == 2'h1) |=> dout_r == $past(out_sh_r[7]);
    endproperty
    a_int_msb: assert property (p_int_msb) else $error("msb not on second fall");

    property p_power_drop;
        (conv_end && !ctrl_r[CB_POWER_KEEP] && !(sclk_rise && !cs_s)) |=> !o_powered;
    endproperty
    a_power_drop: assert property (p_power_drop) else $error("power kept without keep bit");
endmodule
`default_nettype wire

// *** sim/adc_host_model.sv ***
// host serial master model driving the converter link
`default_nettype none
module adc_host_model
(
    input wire logic i_clk_sys,
    input wire logic i_serial_out,
    input wire logic i_serial_out_oe,
    output logic o_chip_sel_n,
    output logic o_serial_clk,
    output logic o_serial_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic so_wire;
    // a released data line shows the inverse so stale data never passes
    assign so_wire = i_serial_out_oe ? i_serial_out : !i_serial_out;
    initial
    begin
        o_chip_sel_n = 1'b1;
        o_serial_clk = 1'b0;
        o_serial_in = 1'b0;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(posedge i_clk_sys);
    endtask
    // one byte each way, msb first; the clock stands low between bytes
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--)
        begin
            o_serial_in <= tx[i];
            wait_clk(4);
            // host masters the clock; bench period is short only to keep runs brief
            o_serial_clk <= 1'b1;
            wait_clk(4);
            rx[i] = so_wire; // late in the high phase, data settled
            o_serial_clk <= 1'b0;
        end
        wait_clk(6);
    endtask
    // framing by chip select around whole bytes
    task automatic select(input logic v);
        @(posedge i_clk_sys);
        o_chip_sel_n <= v;
        wait_clk(6);
    endtask
endmodule
`default_nettype wire

// *** sim/adc_serial_if_tb_top.sv ***
// self-checking bench for the serial converter interface
`default_nettype none
module adc_serial_if_tb_top
    import adc_serial_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst_n, shutdown_n, cs_n, sclk, sdi, so, so_oe, st, st_oe, pwr, pol, cfg, wr, rd;
    logic [7:0] code, rx, r;
    logic [2:0] chan;
    logic [3:0] addr;
    logic [31:0] wdata, rdata, d;
    int fail_count, compares;
    adc_serial_if DUT (.i_clk_sys(clk), .i_rst_n(rst_n), .i_chip_sel_n(cs_n), .i_serial_clk(sclk),
        .i_serial_in(sdi), .i_shutdown_n(shutdown_n), .i_analog_code(code), .i_reg_addr(addr),
        .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .o_serial_out(so),
        .o_serial_out_oe(so_oe), .o_conv_strobe(st), .o_conv_strobe_oe(st_oe), .o_channel_pick(chan),
        .o_polarity_sel(pol), .o_input_config_sel(cfg), .o_powered(pwr));
    adc_host_model u_host (.i_clk_sys(clk), .i_serial_out(so), .i_serial_out_oe(so_oe),
        .o_chip_sel_n(cs_n), .o_serial_clk(sclk), .o_serial_in(sdi));
    // ****
    // shared tasks
    // ****
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic reg_rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask
    // two zero bytes back; expectation padded two zeros ahead, six behind
    task automatic read_result();
        u_host.xfer(8'h00, rx);
        check(rx, {2'b00, r[7:2]});
        u_host.xfer(8'h00, rx);
        check(rx, {r[1:0], 6'h00});
    endtask
    task automatic final_report();
        if (fail_count == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic t_power_on();
        check({st, st_oe, so_oe, pwr}, 4'hC);
        reg_rd(REG_STEP, d);
        check(d, 32'h0000003E);
        reg_rd(REG_STATUS, d);
        check(d & 32'h000000FD, 32'h00000011);
        reg_rd(4'h2, d);
        check(d, 32'h00000000);
        u_host.select(1'b0);
        u_host.xfer(8'h00, rx);
        check(rx, 8'h00);
        u_host.select(1'b1);
    endtask
    // external clock conversion, leading zero byte first
    task automatic t_external(input logic [7:0] ctl, input logic [7:0] c);
        code <= c;
        r = ctl[3] ? c : {~c[7], c[6:0]}; // bipolar gives twos complement
        u_host.select(1'b0);
        u_host.xfer(8'h00, rx);
        u_host.xfer(ctl, rx);
        check(st, 1'b1);
        read_result();
        u_host.select(1'b1);
        check({so_oe, st_oe}, 2'b00);
        check({chan, pol, cfg, pwr}, {ctl[6:2], 1'b1});
        reg_rd(REG_RESULT, d);
        check(d, {24'h000000, r});
        reg_rd(REG_CTRL_BYTE, d);
        check(d, {24'h000000, ctl});
    endtask
    // hard shutdown while idle: power drops, state halts, then recovers
    task automatic t_shutdown();
        @(posedge clk);
        shutdown_n <= 1'b0;
        repeat (4) @(posedge clk);
        check(pwr, 1'b0);
        reg_rd(REG_STATUS, d);
        check(d[7:4], 4'h8);
        @(posedge clk);
        shutdown_n <= 1'b1;
        repeat (4) @(posedge clk);
        reg_rd(REG_STATUS, d);
        check(d[7:4], 4'h1);
    endtask
    // 16-clock cadence: the next control byte rides on the third byte
    task automatic t_cadence();
        code <= 8'h81;
        u_host.select(1'b0);
        u_host.xfer(8'h8F, rx);
        code <= 8'h42;
        u_host.xfer(8'h00, rx);
        check(rx, 8'h20);
        u_host.xfer(8'h8F, rx);
        check(rx, 8'h40);
        r = 8'h42;
        read_result();
        u_host.select(1'b1);
    endtask
    // chip select toggled mid-conversion; the next start replaces it
    task automatic t_abort();
        code <= 8'h11;
        u_host.select(1'b0);
        u_host.xfer(8'h8F, rx);
        u_host.select(1'b1);
        u_host.select(1'b0);
        code <= 8'h6E;
        r = 8'h6E;
        u_host.xfer(8'h8F, rx);
        read_result();
        u_host.select(1'b1);
    endtask
    // internal clock conversion; chip select raised meanwhile
    task automatic t_internal();
        // a zero step would stall the divider, so it reads back as one
        reg_wr(REG_STEP, 32'h00000000);
        reg_rd(REG_STEP, d);
        check(d, 32'h00000001);
        reg_wr(REG_STEP, 32'h00000014);
        code <= 8'h5A;
        r = 8'h5A;
        u_host.select(1'b0);
        u_host.xfer(8'hAC, rx);
        check(st, 1'b0);
        u_host.select(1'b1);
        check({st_oe, so_oe}, 2'b10);
        for (int i = 0; i < 400 && st !== 1'b1; i++)
            @(posedge clk);
        check(st, 1'b1);
        u_host.select(1'b0);
        read_result();
        u_host.select(1'b1);
        check(pwr, 1'b0);
    endtask
    // clock, reset and the watchdog
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial
    begin
        // about three times the expected run length
        #300000;
        fail_count++;
        final_report();
    end
    initial
    begin
        rst_n = 1'b0;
        shutdown_n = 1'b1;
        code = 8'h00;
        addr = 4'h0;
        wdata = 32'h00000000;
        wr = 1'b0;
        rd = 1'b0;
        fail_count = 0;
        compares = 0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        t_power_on();
        t_external(8'hFF, 8'hA5);
        t_shutdown();
        t_external(8'hD7, 8'h3C);
        t_cadence();
        t_abort();
        t_internal();
        final_report();
    end
endmodule
`default_nettype wire
